// ---- design/bit_error_rate_tester.sv ----
// Bit error rate tester: pattern generator, self-synchronising checker,
// per-second performance counters, lead and far-end loopback status.
// Assumes tx_tick/rx_tick bit strobes from port logic on core_clk and
// in-band loop code detection done upstream on the same clock.
`timescale 1ns/1ns
module bit_error_rate_tester #(
	parameter int SEC_CYCLES = bert_pkg::SEC_CYCLES,
	parameter int CW = 32
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rstn,
	// Register port
	input wire logic [7:0] addr,
	input wire logic [31:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [31:0] rdata,
	output logic irq,
	// Serial data port
	input wire logic tx_tick,
	output logic tx_data,
	input wire logic rx_tick,
	input wire logic rx_data,
	// Control leads from the pins
	input wire logic rts_pin,
	input wire logic dtr_pin,
	// Far-end loop code detector
	input wire logic loop_code_valid,
	input wire logic [1:0] loop_code_unit,
	input wire logic loop_code_latching,
	output logic [2:0] remote_loop_state
);
	// Synchronisers for the pins
	logic [2:0] pin_s1_r, pin_s2_r;
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			pin_s1_r <= 3'h0;
			pin_s2_r <= 3'h0;
		end else begin
			pin_s1_r <= {rx_data, dtr_pin, rts_pin};
			pin_s2_r <= pin_s1_r;
		end
	end
	wire rx_bit = pin_s2_r[2];

	// Register decode
	logic [4:0] pat_r;
	logic [1:0] det_r;
	logic [3:0] int_mask_r, int_stat_r;
	wire wr_ctrl = wr && addr == bert_pkg::CTRL_ADDR;
	wire wr_cmd = wr && addr == bert_pkg::CMD_ADDR;
	wire wr_mask = wr && addr == bert_pkg::INT_MASK_ADDR;
	wire rd_int = rd && addr == bert_pkg::INT_STAT_ADDR;
	wire clear_cmd = wr_cmd && wdata[bert_pkg::CMD_CLEAR_BIT];
	wire inject_cmd = wr_cmd && wdata[bert_pkg::CMD_INJECT_BIT];
	wire pat_change = wr_ctrl && wdata[bert_pkg::CTRL_PAT_LSB +: 5] != pat_r;
	// Pattern change starts a new test, so it zeroes counters like a clear
	wire restart = clear_cmd || pat_change;
	wire pat_off = pat_r == bert_pkg::PAT_OFF;
	wire prbs = pat_r == bert_pkg::PAT_P511 || pat_r == bert_pkg::PAT_P2047
		|| pat_r == bert_pkg::PAT_QRSS;

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			pat_r <= bert_pkg::CTRL_PAT_RST;
			det_r <= bert_pkg::CTRL_DET_RST;
			int_mask_r <= bert_pkg::INT_MASK_RST;
		end else begin
			if (wr_ctrl) begin
				pat_r <= wdata[bert_pkg::CTRL_PAT_LSB +: 5]; // R1
				det_r <= wdata[bert_pkg::CTRL_DET_LSB +: 2];
			end
			if (wr_mask)
				int_mask_r <= wdata[3:0];
		end
	end

	// Fixed 16-bit word for repeating patterns; byte patterns latch nothing
	logic [15:0] fixed_word;
	always_comb begin
		case (pat_r)
			bert_pkg::PAT_MARK: fixed_word = 16'hFFFF; // R1
			bert_pkg::PAT_SPACE: fixed_word = 16'h0000;
			bert_pkg::PAT_ALT: fixed_word = 16'hAAAA;
			bert_pkg::PAT_ONE8: fixed_word = 16'h4040;
			bert_pkg::PAT_FF: fixed_word = 16'hFFFF; // R2
			bert_pkg::PAT_7E: fixed_word = 16'h7E7E;
			bert_pkg::PAT_32: fixed_word = 16'h3232;
			bert_pkg::PAT_40: fixed_word = 16'h4040;
			bert_pkg::PAT_OCU_A: fixed_word = {bert_pkg::OCU_CODE, bert_pkg::ALT_FILL}; // R3
			bert_pkg::PAT_CSU_A: fixed_word = {bert_pkg::CSU_CODE, bert_pkg::ALT_FILL};
			bert_pkg::PAT_DSU_A: fixed_word = {bert_pkg::DSU_CODE, bert_pkg::ALT_FILL};
			bert_pkg::PAT_CSU1_A: fixed_word = {bert_pkg::CSU1_CODE, bert_pkg::ALT_FILL};
			bert_pkg::PAT_CSU2_A: fixed_word = {bert_pkg::CSU2_CODE, bert_pkg::ALT_FILL};
			default: fixed_word = 16'h0000;
		endcase
	end

	// Feedback taps shared by generator and checker
	function automatic logic prbs_fb(input logic [4:0] p, input logic [19:0] s);
		case (p)
			bert_pkg::PAT_P511: prbs_fb = s[8] ^ s[4];
			bert_pkg::PAT_P2047: prbs_fb = s[10] ^ s[8];
			default: prbs_fb = s[19] ^ s[16];
		endcase
	endfunction : prbs_fb

	// Generator
	logic [19:0] lfsr_r;
	logic [3:0] tx_idx_r;
	logic inject_pend_r;
	logic [CW-1:0] bits_sent_r;
	wire gen_fb = prbs_fb(pat_r, lfsr_r);
	wire gen_bit = prbs ? gen_fb : fixed_word[4'hF - tx_idx_r];
	wire tx_go = tx_tick && !pat_off;
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			lfsr_r <= 20'hFFFFF;
			tx_idx_r <= 4'h0;
			tx_data <= 1'b1;
			inject_pend_r <= 1'b0;
		end else begin
			if (tx_go) begin
				lfsr_r <= {lfsr_r[18:0], gen_fb};
				tx_idx_r <= tx_idx_r + 4'h1;
				tx_data <= gen_bit ^ inject_pend_r; // R15
			end else if (tx_tick) begin
				// Idle ones wait for a strobe, so the line moves only on bit edges
				tx_data <= 1'b1;
			end
			// A request arriving with the consuming bit stays pending
			if (inject_cmd && !pat_off)
				inject_pend_r <= 1'b1; // R15
			else if (tx_go)
				inject_pend_r <= 1'b0;
		end
	end

	// Checker: predicts each bit from received history, so it locks to
	// any phase of its own looped pattern or a remote source
	logic [19:0] rx_hist_r;
	logic sync_r;
	logic [5:0] good_run_r, win_cnt_r, win_err_r;
	logic [3:0] rx_idx_r;
	logic alt_ok_r;
	wire pred = prbs ? prbs_fb(pat_r, rx_hist_r) : rx_hist_r[15];
	wire rx_go = rx_tick && !pat_off;
	wire bit_err = rx_go && (rx_bit != pred);
	wire sync_gain = rx_go && !sync_r && !bit_err
		&& good_run_r == 6'(bert_pkg::SYNC_GOOD_BITS - 1);
	wire sync_loss = rx_go && sync_r && bit_err
		&& win_err_r == 6'(bert_pkg::SYNC_BAD_ERRS - 1);
	wire count_err = bit_err && sync_r;
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			rx_hist_r <= 20'h00000;
			sync_r <= 1'b0;
			good_run_r <= 6'h00;
			win_cnt_r <= 6'h00;
			win_err_r <= 6'h00;
			rx_idx_r <= 4'h0;
			alt_ok_r <= 1'b0;
		end else if (pat_off || pat_change) begin
			sync_r <= 1'b0;
			good_run_r <= 6'h00;
			alt_ok_r <= 1'b0;
			// The generator counts this strobe too, so word phase stays aligned
			if (rx_go)
				rx_idx_r <= rx_idx_r + 4'h1;
		end else if (rx_go) begin
			rx_hist_r <= {rx_hist_r[18:0], rx_bit};
			good_run_r <= bit_err ? 6'h00 : good_run_r + 6'h01;
			if (sync_gain)
				sync_r <= 1'b1; // R4
			else if (sync_loss)
				sync_r <= 1'b0;
			win_cnt_r <= win_cnt_r + 6'h01;
			if (win_cnt_r == 6'(bert_pkg::SYNC_WINDOW - 1))
				win_err_r <= 6'h00;
			else if (count_err)
				win_err_r <= win_err_r + 6'h01;
			// Alternating result: received word equals the code pair
			rx_idx_r <= rx_idx_r + 4'h1;
			if (pat_r >= bert_pkg::PAT_OCU_A && rx_idx_r == 4'hF)
				alt_ok_r <= {rx_hist_r[14:0], rx_bit} == fixed_word; // R3
		end
	end

	// Saturating counter step
	function automatic logic [CW-1:0] sat_inc(input logic [CW-1:0] v);
		sat_inc = &v ? v : v + CW'(1);
	endfunction : sat_inc

	// One-second timebase
	logic [31:0] tick_cnt_r;
	wire sec_tick = tick_cnt_r == 32'(SEC_CYCLES - 1); // R18
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn)
			tick_cnt_r <= 32'h0;
		else if (sec_tick || restart)
			tick_cnt_r <= 32'h0;
		else
			tick_cnt_r <= tick_cnt_r + 32'h1;
	end

	// Per-second accumulators
	logic [31:0] sec_err_r, sec_bits_r;
	logic sec_unlock_r;
	wire [31:0] sec_err_now = sec_err_r + {31'h0, count_err};
	wire sec_errored = sec_err_now != 32'h0;
	wire [47:0] err_scaled = 48'(sec_err_now) * 48'(bert_pkg::SEVERE_RATIO);
	wire sec_severe = err_scaled > 48'(sec_bits_r); // R7
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			sec_err_r <= 32'h0;
			sec_bits_r <= 32'h0;
			sec_unlock_r <= 1'b0;
		end else if (sec_tick || restart) begin
			sec_err_r <= 32'h0;
			sec_bits_r <= 32'h0;
			sec_unlock_r <= 1'b0;
		end else begin
			sec_err_r <= sec_err_now;
			if (tx_go)
				sec_bits_r <= sec_bits_r + 32'h1;
			if (!sync_r && !pat_off)
				sec_unlock_r <= 1'b1;
		end
	end

	// Performance counters
	logic [CW-1:0] err_total_r, err_sec_r, sev_sec_r, cons_sev_r;
	logic [CW-1:0] unlock_sec_r, elapsed_r;
	logic [3:0] sev_run_r, clean_run_r;
	logic cons_active_r;
	wire run_go = sec_tick && !pat_off;
	wire sev_start = sec_severe && sev_run_r == 4'(bert_pkg::SEVERE_RUN - 1);
	wire clean_end = !sec_severe && clean_run_r == 4'(bert_pkg::SEVERE_RUN - 1);
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			err_total_r <= '0;
			err_sec_r <= '0;
			sev_sec_r <= '0;
			cons_sev_r <= '0;
			unlock_sec_r <= '0;
			elapsed_r <= '0;
			bits_sent_r <= '0;
			sev_run_r <= 4'h0;
			clean_run_r <= 4'h0;
			cons_active_r <= 1'b0;
		end else if (restart) begin
			err_total_r <= '0; // R16
			err_sec_r <= '0;
			sev_sec_r <= '0;
			cons_sev_r <= '0;
			unlock_sec_r <= '0;
			elapsed_r <= '0;
			bits_sent_r <= '0;
			sev_run_r <= 4'h0;
			clean_run_r <= 4'h0;
			cons_active_r <= 1'b0;
		end else begin
			if (count_err)
				err_total_r <= sat_inc(err_total_r); // R5
			if (tx_go)
				bits_sent_r <= sat_inc(bits_sent_r); // R10
			if (run_go) begin
				elapsed_r <= sat_inc(elapsed_r); // R11
				if (sec_errored)
					err_sec_r <= sat_inc(err_sec_r); // R6
				if (sec_severe)
					sev_sec_r <= sat_inc(sev_sec_r); // R7
				if (sec_unlock_r || !sync_r)
					unlock_sec_r <= sat_inc(unlock_sec_r); // R9
				sev_run_r <= sec_severe ? (sev_start ? sev_run_r : sev_run_r + 4'h1) : 4'h0;
				clean_run_r <= sec_severe ? 4'h0 : (clean_end ? clean_run_r : clean_run_r + 4'h1);
				if (sev_start)
					cons_active_r <= 1'b1; // R8
				else if (clean_end)
					cons_active_r <= 1'b0;
				if (cons_active_r || sev_start)
					cons_sev_r <= sat_inc(cons_sev_r); // R8
			end
		end
	end

	// Far-end loopback state and timed release
	logic [9:0] loop_sec_r;
	wire loop_req = loop_code_valid && det_r != bert_pkg::DET_OFF;
	wire loop_timeout = det_r == bert_pkg::DET_TIMED && remote_loop_state != 3'h0
		&& sec_tick && loop_sec_r == 10'(bert_pkg::LOOP_TIMEOUT_SEC - 1);
	wire [2:0] loop_next = loop_code_unit == bert_pkg::UNIT_NONE ? 3'h0
		: {!loop_code_latching, loop_code_unit};
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			remote_loop_state <= 3'h0;
			loop_sec_r <= 10'h000;
		end else if (loop_req) begin
			remote_loop_state <= loop_next; // R14
			loop_sec_r <= 10'h000;
		end else if (loop_timeout || det_r == bert_pkg::DET_OFF) begin
			remote_loop_state <= 3'h0; // R17
			loop_sec_r <= 10'h000;
		end else if (sec_tick && remote_loop_state != 3'h0) begin
			loop_sec_r <= loop_sec_r + 10'h001; // R17
		end
	end

	// Interrupt status: set wins over the clearing read
	logic [2:0] loop_prev_r;
	wire [3:0] int_events = {run_go && sec_errored, remote_loop_state != loop_prev_r,
		sync_loss, sync_gain};
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			int_stat_r <= 4'h0;
			loop_prev_r <= 3'h0;
			irq <= 1'b0;
		end else begin
			int_stat_r <= (rd_int ? 4'h0 : int_stat_r) | int_events;
			loop_prev_r <= remote_loop_state;
			irq <= |((rd_int ? 4'h0 : int_stat_r) & int_mask_r)
				|| |(int_events & int_mask_r);
		end
	end

	// Read mux
	wire [31:0] status_word = {25'h0, alt_ok_r, remote_loop_state, // R14
		pin_s2_r[1], pin_s2_r[0], sync_r}; // R13 R12
	logic [31:0] rd_mux;
	always_comb begin
		case (addr)
			bert_pkg::CTRL_ADDR: rd_mux = {22'h0, det_r, 3'h0, pat_r};
			bert_pkg::STATUS_ADDR: rd_mux = status_word;
			bert_pkg::INT_STAT_ADDR: rd_mux = {28'h0, int_stat_r};
			bert_pkg::INT_MASK_ADDR: rd_mux = {28'h0, int_mask_r};
			bert_pkg::ERR_TOTAL_ADDR: rd_mux = 32'(err_total_r);
			bert_pkg::ERR_SEC_ADDR: rd_mux = 32'(err_sec_r);
			bert_pkg::SEV_SEC_ADDR: rd_mux = 32'(sev_sec_r);
			bert_pkg::CONS_SEV_ADDR: rd_mux = 32'(cons_sev_r);
			bert_pkg::UNLOCK_SEC_ADDR: rd_mux = 32'(unlock_sec_r);
			bert_pkg::ELAPSED_ADDR: rd_mux = 32'(elapsed_r);
			bert_pkg::BITS_SENT_ADDR: rd_mux = 32'(bits_sent_r);
			default: rd_mux = 32'h0;
		endcase
	end
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn)
			rdata <= 32'h0;
		else
			rdata <= rd ? rd_mux : 32'h0;
	end
endmodule : bit_error_rate_tester

// ---- inc/bert_pkg.sv ----
// Constants, register map and pattern codes of the bit error rate tester.
// Assumes a 10 MHz core clock and a plain address/strobe register port.
// Summary of operation
// R1: Patterns off, ones, zeros, 1:1, one-in-eight, 511, 2047 and quasi-random source.
// R2: Byte patterns 1111-1111, 0111-1110, 0011-0010, 0100-0000; they latch no loopback.
// R3: Send alternating-byte loop patterns for office, service, repeater and data units; report result.
// R4: Raise sync once the checker locks to its own looped or a remote pattern.
// R5: Total the bit errors seen since the last clear.
// R6: Count each second holding at least one bit error.
// R7: Count each second whose error ratio exceeds one per thousand bits.
// R8: After ten severe seconds in a row count every second until ten clean seconds.
// R9: Count every second during which the checker is out of sync.
// R10: Report error ratio as error total over bits sent in this test.
// R11: Count whole seconds elapsed since the test began.
// R12: Report request-to-send lead level.
// R13: Report data-terminal-ready lead level.
// R14: Report far-end loopback: none, latching or non-latching office, data or service unit.
// R15: One inject command inverts exactly one transmitted bit.
// R16: Clear command zeroes every error, second and elapsed counter.
// R17: In timed detect mode release a far-end loopback ten minutes after set up.
// R18: Per-second counters step on a derived one-second strobe and saturate.
package bert_pkg;
	localparam int CLK_HZ = 10_000_000;
	localparam int ONE_SEC_S = 1;
	localparam int SEC_CYCLES = ONE_SEC_S * CLK_HZ;
	localparam int LOOP_TIMEOUT_MIN = 10;
	localparam int LOOP_TIMEOUT_SEC = LOOP_TIMEOUT_MIN * 60;
	localparam int SEVERE_RUN = 10;
	localparam int SEVERE_RATIO = 1000;
	localparam int SYNC_GOOD_BITS = 32;
	localparam int SYNC_BAD_ERRS = 16;
	localparam int SYNC_WINDOW = 64;

	localparam logic [7:0] CTRL_ADDR = 8'h00;
	localparam logic [7:0] CMD_ADDR = 8'h04;
	localparam logic [7:0] STATUS_ADDR = 8'h08;
	localparam logic [7:0] INT_STAT_ADDR = 8'h0C;
	localparam logic [7:0] INT_MASK_ADDR = 8'h10;
	localparam logic [7:0] ERR_TOTAL_ADDR = 8'h14;
	localparam logic [7:0] ERR_SEC_ADDR = 8'h18;
	localparam logic [7:0] SEV_SEC_ADDR = 8'h1C;
	localparam logic [7:0] CONS_SEV_ADDR = 8'h20;
	localparam logic [7:0] UNLOCK_SEC_ADDR = 8'h24;
	localparam logic [7:0] ELAPSED_ADDR = 8'h28;
	localparam logic [7:0] BITS_SENT_ADDR = 8'h2C;

	localparam int CTRL_PAT_LSB = 0;
	localparam int CTRL_DET_LSB = 8;
	localparam int CMD_INJECT_BIT = 0;
	localparam int CMD_CLEAR_BIT = 1;
	localparam logic [4:0] CTRL_PAT_RST = 5'h00;
	localparam logic [1:0] CTRL_DET_RST = 2'h2;
	localparam logic [3:0] INT_MASK_RST = 4'h0;

	localparam logic [7:0] OCU_CODE = 8'h01;
	localparam logic [7:0] CSU_CODE = 8'h02;
	localparam logic [7:0] DSU_CODE = 8'h03;
	localparam logic [7:0] CSU1_CODE = 8'h04;
	localparam logic [7:0] CSU2_CODE = 8'h05;
	localparam logic [7:0] ALT_FILL = 8'hFF;

	typedef enum logic [4:0] {
		PAT_OFF = 5'h00, PAT_MARK = 5'h01, PAT_SPACE = 5'h02, PAT_ALT = 5'h03,
		PAT_ONE8 = 5'h04, PAT_P511 = 5'h05, PAT_QRSS = 5'h06, PAT_P2047 = 5'h07,
		PAT_FF = 5'h08, PAT_7E = 5'h09, PAT_32 = 5'h0A, PAT_40 = 5'h0B,
		PAT_OCU_A = 5'h0C, PAT_CSU_A = 5'h0D, PAT_DSU_A = 5'h0E,
		PAT_CSU1_A = 5'h0F, PAT_CSU2_A = 5'h10
	} pattern_t;

	typedef enum logic [1:0] {
		DET_OFF = 2'h0, DET_ON = 2'h1, DET_TIMED = 2'h2
	} detect_t;

	// Loop state code: bit 2 set means non-latching, low bits the unit
	localparam logic [1:0] UNIT_NONE = 2'h0;
endpackage : bert_pkg

// ---- dv/bert_monitor.sv ----
// Port checker for the bit error rate tester.
// Bound to the top module; sees only its ports, one clock domain.
`timescale 1ns/1ns
module bert_monitor (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rstn,
	// Register port
	input wire logic [7:0] addr,
	input wire logic rd,
	input wire logic [31:0] rdata,
	input wire logic irq,
	// Data, leads and loop codes
	input wire logic tx_tick,
	input wire logic tx_data,
	input wire logic rts_pin,
	input wire logic dtr_pin,
	input wire logic loop_code_valid,
	input wire logic [1:0] loop_code_unit,
	input wire logic loop_code_latching,
	input wire logic [2:0] remote_loop_state
);
	logic [2:0] rts_r;
	logic [2:0] dtr_r;
	// Leads pass a synchroniser, so only a lead quiet for a while is compared
	wire stat_rd = rd && addr == bert_pkg::STATUS_ADDR;
	wire rts_calm = rts_r == {3{rts_pin}};
	wire dtr_calm = dtr_r == {3{dtr_pin}};
	wire [2:0] code_state = {!loop_code_latching, loop_code_unit};
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rstn);
	always_ff @(posedge core_clk) rts_r <= {rts_r[1:0], rts_pin};
	always_ff @(posedge core_clk) dtr_r <= {dtr_r[1:0], dtr_pin};

	a_rdata_idle: assert property (!rd |=> rdata == 32'h0)
		else $error("read data not zero outside a read answer");
	a_unmapped_zero: assert property (rd && addr == 8'h30 |=> rdata == 32'h0)
		else $error("unmapped read returned data");
	a_rts_report: assert property (stat_rd && rts_calm |=> rdata[1] == $past(rts_pin))
		else $error("status shows wrong request-to-send level");
	a_dtr_report: assert property (stat_rd && dtr_calm |=> rdata[2] == $past(dtr_pin))
		else $error("status shows wrong terminal-ready level");
	a_loop_set: assert property (loop_code_valid && loop_code_unit != 2'h0 |=>
		remote_loop_state == $past(code_state) || remote_loop_state == 3'h0)
		else $error("loop state does not follow loop code");
	a_loop_drop: assert property (loop_code_valid && loop_code_unit == 2'h0 |=>
		remote_loop_state == 3'h0)
		else $error("loop state not released by loop-down code");
	a_loop_hold: assert property (!loop_code_valid |=>
		$stable(remote_loop_state) || remote_loop_state == 3'h0)
		else $error("loop state changed without a code");
	a_loop_legal: assert property (remote_loop_state != 3'h4)
		else $error("loop state holds an unused code");
	a_tx_steady: assert property (!tx_tick |=> $stable(tx_data))
		else $error("transmit bit changed without a bit strobe");

	c_sync_read: cover property (stat_rd ##1 rdata[0]);
	c_irq_rise: cover property ($rose(irq));
	c_loop_csu: cover property (remote_loop_state == 3'h3);
	c_loop_gone: cover property ($fell(remote_loop_state != 3'h0));
endmodule : bert_monitor

bind bit_error_rate_tester bert_monitor bert_monitor_i (.core_clk, .rstn, .addr, .rd, .rdata,
	.irq, .tx_tick, .tx_data, .rts_pin, .dtr_pin, .loop_code_valid, .loop_code_unit,
	.loop_code_latching, .remote_loop_state);

// ---- dv/far_end_model.sv ----
// Far-end loopback: returns the sent stream with its own bit strobe.
// Assumes tx_tick at most once every 4 cycles; slow adds two cycles of path delay.
`timescale 1ns/1ns
module far_end_model (
	// Clock
	input wire logic core_clk,
	// Near-end transmit side
	input wire logic tx_tick,
	input wire logic tx_data,
	// Path faults and speed
	input wire logic slow,
	input wire logic invert_all,
	input wire logic noisy,
	// Returned stream
	output logic rx_tick,
	output logic rx_data
);
	logic [5:0] tick_r = 6'h0;
	logic [2:0] data_r = 3'h0;
	logic [3:0] bit_cnt_r = 4'h0;
	// One bit in sixteen is hit: enough for a bad second, too few to lose sync
	wire hit = invert_all || (noisy && bit_cnt_r == 4'h0);
	always_ff @(posedge core_clk) begin
		tick_r <= {tick_r[4:0], tx_tick};
		data_r <= {data_r[1:0], tx_data ^ hit};
		if (tx_tick)
			bit_cnt_r <= bit_cnt_r + 4'h1;
	end
	// The stream comes straight back, so the checker can lock to its own pattern
	assign rx_tick = slow ? tick_r[5] : tick_r[3];
	assign rx_data = slow ? data_r[2] : data_r[0];
endmodule : far_end_model

// ---- dv/tb.sv ----
// Self-checking bench for the bit error rate tester behind a far-end loopback.
// Assumes the designer's register map and a second shortened to SC cycles.
`timescale 1ns/1ns
module tb;
	localparam int SC = 64;
	typedef struct {logic [7:0] a; logic rts; logic dtr; logic [31:0] m; logic [31:0] e;} reg_row_t;
	typedef struct {logic [4:0] p; logic [15:0] w; logic fix;} pat_row_t;
	logic core_clk = 1'b0;
	logic rstn = 1'b0;
	logic [7:0] addr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic tx_tick = 1'b0;
	logic rts_pin = 1'b0;
	logic dtr_pin = 1'b0;
	logic loop_code_valid = 1'b0;
	logic [1:0] loop_code_unit = 2'h0;
	logic loop_code_latching = 1'b0;
	logic slow = 1'b0;
	logic invert_all = 1'b0;
	logic noisy = 1'b0;
	logic [31:0] rdata;
	logic [2:0] remote_loop_state;
	logic irq, tx_data, rx_tick, rx_data;
	logic [15:0] cap;
	logic [31:0] got, prev;
	int fail_count = 0;
	int num_checks = 0;
	int cycles = 0;
	int zeros = 0;
	reg_row_t regs[8] = '{'{8'h00, 0, 0, 32'h3FF, 32'h200}, '{8'h10, 0, 0, 32'hF, 32'h0},
		'{8'h14, 0, 0, '1, 32'h0}, '{8'h28, 0, 0, '1, 32'h0}, '{8'h30, 0, 0, '1, 32'h0},
		'{8'h08, 1, 0, 32'h6, 32'h2}, '{8'h08, 0, 1, 32'h6, 32'h4}, '{8'h08, 1, 1, 32'h6, 32'h6}};
	pat_row_t pats[17] = '{'{5'h00, 16'hFFFF, 1}, '{5'h01, 16'hFFFF, 1}, '{5'h02, 16'h0000, 1},
		'{5'h03, 16'hAAAA, 1}, '{5'h04, 16'h4040, 1}, '{5'h05, 16'h0, 0}, '{5'h06, 16'h0, 0},
		'{5'h07, 16'h0, 0}, '{5'h08, 16'hFFFF, 1}, '{5'h09, 16'h7E7E, 1}, '{5'h0A, 16'h3232, 1},
		'{5'h0B, 16'h4040, 1}, '{5'h0C, 16'h01FF, 1}, '{5'h0D, 16'h02FF, 1},
		'{5'h0E, 16'h03FF, 1}, '{5'h0F, 16'h04FF, 1}, '{5'h10, 16'h05FF, 1}};

	bit_error_rate_tester #(.SEC_CYCLES(SC)) bit_error_rate_tester_i (.core_clk, .rstn, .addr,
		.wdata, .wr, .rd, .rdata, .irq, .tx_tick, .tx_data, .rx_tick, .rx_data, .rts_pin,
		.dtr_pin, .loop_code_valid, .loop_code_unit, .loop_code_latching, .remote_loop_state);
	far_end_model far_end_model_i (.core_clk, .tx_tick, .tx_data, .slow, .invert_all, .noisy,
		.rx_tick, .rx_data);

	task automatic final_report;
		$display("Checks %0d, mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : final_report
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		num_checks++;
		if (g !== e) begin
			fail_count++;
			$display("ERROR %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	task automatic chk_rng(input string n, input int lo, input int hi, input logic [31:0] g);
		num_checks++;
		if ($isunknown(g) || g < lo || g > hi) begin
			fail_count++;
			$display("ERROR %s expected %0d..%0d seen %h", n, lo, hi, g);
		end
	endtask : chk_rng
	task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk) begin
			addr <= a;
			wdata <= d;
			wr <= 1'b1;
		end
		@(posedge core_clk) wr <= 1'b0;
	endtask : wr_reg
	task automatic rd_reg(input logic [7:0] a);
		@(posedge core_clk) begin
			addr <= a;
			rd <= 1'b1;
		end
		@(posedge core_clk) rd <= 1'b0;
		#1 got = rdata;
	endtask : rd_reg
	// Bits are captured as they leave, one strobe every four cycles
	task automatic send_bits(input int n);
		repeat (n) begin
			@(posedge core_clk) tx_tick <= 1'b1;
			@(posedge core_clk) tx_tick <= 1'b0;
			#1 cap = {cap[14:0], tx_data};
			zeros += int'(!tx_data);
			repeat (2) @(posedge core_clk);
		end
	endtask : send_bits
	task automatic pulse_loop(input logic [1:0] u, input logic l, input logic en);
		@(posedge core_clk) begin
			loop_code_valid <= 1'b1;
			loop_code_unit <= u;
			loop_code_latching <= l;
		end
		@(posedge core_clk) loop_code_valid <= 1'b0;
		repeat (2) @(posedge core_clk);
		#1 chk("loop state", !en ? 32'h0 : (l ? {29'h0, 1'b0, u} : {29'h0, 1'b1, u}),
			{29'h0, remote_loop_state});
	endtask : pulse_loop
	function automatic logic rot_ok(input logic [15:0] c, input logic [15:0] w);
		for (int i = 0; i < 16; i++) begin
			if (c === 16'({w, w} >> i))
				return 1'b1;
		end
		return 1'b0;
	endfunction : rot_ok

	initial forever #50 core_clk = ~core_clk;
	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 95000) begin
			fail_count++;
			final_report();
		end
	end

	initial begin
		repeat (19) @(posedge core_clk);
		#1 chk("reset pins", 32'h8, {rdata[26:0], irq, tx_data, remote_loop_state});
		@(posedge core_clk) rstn <= 1'b1;
		foreach (regs[i]) begin
			rts_pin <= regs[i].rts;
			dtr_pin <= regs[i].dtr;
			repeat (4) @(posedge core_clk);
			rd_reg(regs[i].a);
			chk("register", regs[i].e, got & regs[i].m);
		end
		foreach (pats[i]) begin
			wr_reg(bert_pkg::CTRL_ADDR, 32'h200 | pats[i].p);
			send_bits(80);
			rd_reg(bert_pkg::STATUS_ADDR);
			chk("sync", {31'h0, pats[i].p != 5'h00}, {31'h0, got[0]});
			if (pats[i].fix)
				chk("pattern word", 32'h1, {31'h0, rot_ok(cap, pats[i].w)});
			if (pats[i].p >= 5'h0C)
				chk("alternating result", 32'h1, {31'h0, got[6]});
		end
		rd_reg(bert_pkg::INT_STAT_ADDR);
		chk("sync events", 32'h1, got & 32'h3);
		wr_reg(bert_pkg::CTRL_ADDR, 32'h201);
		send_bits(40);
		wr_reg(bert_pkg::CMD_ADDR, 32'h1);
		zeros = 0;
		send_bits(40);
		chk("inverted bits", 32'h1, zeros);
		wr_reg(bert_pkg::CTRL_ADDR, 32'h205);
		send_bits(80);
		wr_reg(bert_pkg::CMD_ADDR, 32'h2);
		rd_reg(bert_pkg::ERR_TOTAL_ADDR);
		chk("error total", 32'h0, got);
		rd_reg(bert_pkg::BITS_SENT_ADDR);
		chk("bits sent", 32'h0, got);
		wr_reg(bert_pkg::CMD_ADDR, 32'h1);
		send_bits(40);
		rd_reg(bert_pkg::ERR_TOTAL_ADDR);
		chk_rng("error total", 1, 3, got);
		rd_reg(bert_pkg::BITS_SENT_ADDR);
		chk("bits sent", 32'd40, got);
		rd_reg(bert_pkg::ELAPSED_ADDR);
		chk_rng("elapsed", 2, 3, got);
		send_bits(32);
		rd_reg(bert_pkg::ERR_SEC_ADDR);
		chk_rng("errored seconds", 1, 2, got);
		rd_reg(bert_pkg::SEV_SEC_ADDR);
		chk_rng("severe seconds", 1, 2, got);
		chk("masked irq", 32'h0, {31'h0, irq});
		wr_reg(bert_pkg::INT_MASK_ADDR, 32'h8);
		repeat (2) @(posedge core_clk);
		#1 chk("irq", 32'h1, {31'h0, irq});
		rd_reg(bert_pkg::INT_STAT_ADDR);
		chk("errored event", 32'h8, got & 32'h8);
		repeat (2) @(posedge core_clk);
		#1 chk("irq cleared", 32'h0, {31'h0, irq});
		wr_reg(bert_pkg::CMD_ADDR, 32'h2);
		noisy <= 1'b1;
		send_bits(192);
		noisy <= 1'b0;
		rd_reg(bert_pkg::SEV_SEC_ADDR);
		chk_rng("severe seconds", 11, 13, got);
		send_bits(192);
		rd_reg(bert_pkg::CONS_SEV_ADDR);
		chk_rng("consecutive severe", 10, 14, got);
		prev = got;
		send_bits(48);
		rd_reg(bert_pkg::CONS_SEV_ADDR);
		chk("consecutive steady", prev, got);
		wr_reg(bert_pkg::CMD_ADDR, 32'h2);
		invert_all <= 1'b1;
		send_bits(80);
		invert_all <= 1'b0;
		rd_reg(bert_pkg::UNLOCK_SEC_ADDR);
		chk_rng("unlocked seconds", 3, 5, got);
		rd_reg(bert_pkg::INT_STAT_ADDR);
		chk("sync lost event", 32'h2, got & 32'h2);
		slow <= 1'b1;
		send_bits(80);
		rd_reg(bert_pkg::STATUS_ADDR);
		chk("slow resync", 32'h1, {31'h0, got[0]});
		for (int u = 1; u < 4; u++)
			for (int l = 0; l < 2; l++)
				pulse_loop(2'(u), 1'(l), 1'b1);
		pulse_loop(2'h0, 1'b1, 1'b1);
		rd_reg(bert_pkg::INT_STAT_ADDR);
		chk("loop event", 32'h4, got & 32'h4);
		wr_reg(bert_pkg::CTRL_ADDR, 32'h005);
		pulse_loop(2'h3, 1'b1, 1'b0);
		chk("detect off", 32'h0, {29'h0, remote_loop_state});
		// Plain detect mode must hold the loop past the timed-release point
		wr_reg(bert_pkg::CTRL_ADDR, 32'h105);
		pulse_loop(2'h2, 1'b1, 1'b1);
		repeat ((bert_pkg::LOOP_TIMEOUT_SEC + 2) * SC) @(posedge core_clk);
		#1 chk("loop kept", 32'h2, {29'h0, remote_loop_state});
		wr_reg(bert_pkg::CTRL_ADDR, 32'h205);
		pulse_loop(2'h3, 1'b1, 1'b1);
		repeat ((bert_pkg::LOOP_TIMEOUT_SEC - 2) * SC) @(posedge core_clk);
		#1 chk("loop held", 32'h3, {29'h0, remote_loop_state});
		repeat (4 * SC) @(posedge core_clk);
		#1 chk("loop released", 32'h0, {29'h0, remote_loop_state});
		final_report();
	end
endmodule : tb
